// *** rtl/lp_ctrl_pkg.sv ***
// constants, types and register map for the line printer I/O controller
// assumes one 100 MHz clock shared with the host I/O bus logic
package lp_ctrl_pkg;

   // clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SRQ_HOLDOFF_NS = 2000;
   localparam int SRQ_HOLDOFF_CYC = (SRQ_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADV_MIN_NS = 100;
   localparam int ADV_MIN_CYC = (ADV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // line buffer
   localparam int LINE_CHARS = 20;
   localparam logic [4:0] LAST_COL_IDX = 5'h13;
   localparam logic [4:0] COUNT_FULL = 5'h14;

   // control output operation codes (low byte of the word)
   localparam logic [7:0] OP_INHIBIT = 8'h04;
   localparam logic [7:0] OP_ALLOW = 8'h08;

   // characters
   localparam logic [7:0] CHAR_PAPER_FEED = 8'h0A;
   localparam logic [7:0] CHAR_FORM_FEED = 8'h0C;
   localparam logic [7:0] CHAR_CARRIAGE_RET = 8'h0D;
   localparam logic [6:0] NOP_BITS = 7'h00;

   // status input word
   localparam int STAT_NOT_READY_BIT = 15;

   // APB register map
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   localparam logic [11:0] LINES_OFFSET = 12'h008;
   // reset device address, value arbitrary
   localparam logic [7:0] DEV_ADDR_RESET = 8'h2A;
   localparam int STS_ALLOW_BIT = 0;
   localparam int STS_SRQ_BIT = 1;
   localparam int STS_NOT_READY_BIT = 2;
   localparam int STS_COUNT_LSB = 8;
   localparam int STS_STATE_LSB = 16;

   typedef enum logic [1:0]
   {
      KIND_CONTROL_OUT = 2'b00,
      KIND_DATA_OUT = 2'b01,
      KIND_STATUS_IN = 2'b10,
      KIND_ADDRESS_IN = 2'b11
   } instr_kind_t;

   typedef enum logic [1:0]
   {
      ADV_NONE = 2'b00,
      ADV_PAPER_FEED = 2'b01,
      ADV_FORM_FEED = 2'b10,
      ADV_CARRIAGE_RET = 2'b11
   } paper_action_t;

   typedef enum logic [1:0]
   {
      CLS_NOP = 2'b00,
      CLS_PRINTABLE = 2'b01,
      CLS_FORMAT = 2'b10
   } char_class_t;

   typedef enum logic [2:0]
   {
      ST_FILL = 3'b000,
      ST_BYTE_LEFT = 3'b001,
      ST_BYTE_RIGHT = 3'b010,
      ST_PRINT = 3'b011,
      ST_ADVANCE = 3'b100,
      ST_SETTLE = 3'b101
   } lp_state_t;

   typedef struct packed
   {
      logic strobe;
      instr_kind_t kind;
      logic [7:0] device_select_field;
      logic [15:0] wdata;
   } io_req_t;

   typedef struct packed
   {
      logic power_ok;
      logic gate_open;
      logic paper_fault;
      logic overtemp;
      logic online;
      logic busy;
   } printer_pins_t;

endpackage

// *** rtl/line_printer_io_controller.sv ***
// line printer controller on the host programmed data channel
// host I/O bus logic runs on pclk; printer pins are asynchronous
//
// Summary of operation
// - control output selects us only when all eight address bits match
// - code 04 sets inhibit-interrupt, 08 allow-interrupt; both acknowledged
// - a control output never raises a service request
// - in allow mode, raise service request when buffer becomes empty
// - an acknowledged inhibit control output drops the service request
// - data output and status input decode all eight address bits
// - data output acknowledged only when the word is taken into the buffer
// - left byte to odd column, right byte to next even column, except no-ops
// - an acknowledged data output drops the service request
// - status input returns bit 15 set while the printer is not ready
// - status input is never acknowledged
// - status input with our address drops the service request
// - address input ignores select field; returns our address if requesting and first
// - address input is never acknowledged
// - address input drops our request when requesting and first in precedence
// - twenty characters held; the twentieth prints the line, next zone follows
// - format characters print the buffer, move paper, restart at column one
// - bytes with bits zero to six zero are no-ops, no column advance
// - data output is refused while the printer is not ready, while a word is being handled, or during the holdoff
// - next service request no sooner than two microseconds after data accept
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module line_printer_io_controller
   import lp_ctrl_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // host I/O bus
   input wire io_req_t io_req,
   input wire logic precedence_in,
   output logic io_ack,
   output logic io_rvalid,
   output logic [15:0] io_rdata,
   output logic service_req,
   output logic precedence_out,
   // printer
   input wire printer_pins_t prn_pins,
   output logic prn_strobe,
   output logic [7:0] prn_char,
   output logic [4:0] prn_column,
   output logic prn_advance,
   output paper_action_t prn_action
);

   function automatic char_class_t classify(input logic [7:0] ch);
      if (ch[6:0] == NOP_BITS)
         classify = CLS_NOP;
      else if (ch == CHAR_PAPER_FEED || ch == CHAR_FORM_FEED || ch == CHAR_CARRIAGE_RET)
         classify = CLS_FORMAT;
      else
         classify = CLS_PRINTABLE;
   endfunction

   function automatic paper_action_t action_of(input logic [7:0] ch);
      if (ch == CHAR_PAPER_FEED)
         action_of = ADV_PAPER_FEED;
      else if (ch == CHAR_FORM_FEED)
         action_of = ADV_FORM_FEED;
      else
         action_of = ADV_CARRIAGE_RET;
   endfunction

   // printer pin synchronisers
   printer_pins_t pins_meta_reg;
   printer_pins_t pins_sync_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pins_meta_reg <= '0;
         pins_sync_reg <= '0;
      end
      else
      begin
         pins_meta_reg <= prn_pins;
         pins_sync_reg <= pins_meta_reg;
      end
   end

   logic not_ready;
   assign not_ready = !pins_sync_reg.power_ok || pins_sync_reg.gate_open ||
                      pins_sync_reg.paper_fault || pins_sync_reg.overtemp ||
                      !pins_sync_reg.online;

   // control state
   logic [7:0] dev_addr_reg;
   logic allow_reg;
   logic srq_reg;
   lp_state_t state_reg;
   logic [4:0] count_reg;
   logic [4:0] idx_reg;
   logic [15:0] word_reg;
   paper_action_t action_reg;
   lp_state_t resume_reg;
   logic [7:0] holdoff_reg;
   logic [7:0] settle_reg;
   logic [15:0] lines_reg;
   logic can_take_d_reg;
   logic [7:0] line_buf [LINE_CHARS];

   // instruction decode
   logic selected;
   logic ctrl_hit;
   logic ctrl_valid_op;
   logic data_hit;
   logic data_accept;
   logic status_hit;
   logic addr_instr;
   logic addr_respond;
   logic can_take;
   assign selected = io_req.strobe && (io_req.device_select_field == dev_addr_reg);
   assign ctrl_hit = selected && io_req.kind == KIND_CONTROL_OUT;
   assign ctrl_valid_op = io_req.wdata[7:0] == OP_INHIBIT || io_req.wdata[7:0] == OP_ALLOW;
   assign data_hit = selected && io_req.kind == KIND_DATA_OUT;
   assign status_hit = selected && io_req.kind == KIND_STATUS_IN;
   assign addr_instr = io_req.strobe && io_req.kind == KIND_ADDRESS_IN;
   assign addr_respond = addr_instr && srq_reg && precedence_in;
   assign can_take = state_reg == ST_FILL && holdoff_reg == 8'h00;
   assign data_accept = data_hit && can_take && !not_ready;

   // interrupt mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         allow_reg <= 1'b0;
      else if (ctrl_hit && ctrl_valid_op)
         allow_reg <= io_req.wdata[7:0] == OP_ALLOW;
   end

   // answers on the host bus, one cycle after the strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         io_ack <= 1'b0;
         io_rvalid <= 1'b0;
         io_rdata <= 16'h0000;
      end
      else
      begin
         io_ack <= (ctrl_hit && ctrl_valid_op) || data_accept;
         io_rvalid <= status_hit || addr_instr;
         if (status_hit)
         begin
            io_rdata <= 16'h0000;
            io_rdata[STAT_NOT_READY_BIT] <= not_ready;
         end
         else if (addr_respond)
            io_rdata <= {8'h00, dev_addr_reg};
         else
            io_rdata <= 16'h0000;
      end
   end

   // service request: raised on the edge of buffer-empty so that a drop by
   // status input is not undone at once; a raise in the same cycle wins over any drop except inhibit
   logic srq_set;
   logic srq_clear;
   assign srq_set = can_take && !can_take_d_reg && allow_reg;
   assign srq_clear = (ctrl_hit && ctrl_valid_op && io_req.wdata[7:0] == OP_INHIBIT)
                    || data_accept
                    || status_hit
                    || addr_respond;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         srq_reg <= 1'b0;
         can_take_d_reg <= 1'b0;
         precedence_out <= 1'b0;
      end
      else
      begin
         can_take_d_reg <= can_take;
         if (!allow_reg || (ctrl_hit && io_req.wdata[7:0] == OP_INHIBIT))
            srq_reg <= 1'b0;
         else if (srq_set)
            srq_reg <= 1'b1;
         else if (srq_clear)
            srq_reg <= 1'b0;
         precedence_out <= precedence_in && !srq_reg;
      end
   end
   assign service_req = srq_reg;

   // holdoff after each accepted word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         holdoff_reg <= 8'h00;
      else if (data_accept)
         holdoff_reg <= 8'(SRQ_HOLDOFF_CYC);
      else if (holdoff_reg != 8'h00)
         holdoff_reg <= holdoff_reg - 8'h01;
   end

   // character handling
   logic [7:0] cur_byte;
   char_class_t cur_class;
   lp_state_t after_byte;
   assign cur_byte = (state_reg == ST_BYTE_LEFT) ? word_reg[15:8] : word_reg[7:0];
   assign cur_class = classify(cur_byte);
   assign after_byte = (state_reg == ST_BYTE_LEFT) ? ST_BYTE_RIGHT : ST_FILL;

   always_ff @(posedge pclk)
   begin
      if ((state_reg == ST_BYTE_LEFT || state_reg == ST_BYTE_RIGHT) &&
          cur_class == CLS_PRINTABLE)
         line_buf[count_reg] <= cur_byte;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_FILL;
         count_reg <= 5'h00;
         idx_reg <= 5'h00;
         word_reg <= 16'h0000;
         action_reg <= ADV_NONE;
         resume_reg <= ST_FILL;
         settle_reg <= 8'h00;
         lines_reg <= 16'h0000;
      end
      else
      begin
         case (state_reg)
            ST_FILL:
            begin
               if (data_accept)
               begin
                  word_reg <= io_req.wdata;
                  state_reg <= ST_BYTE_LEFT;
               end
            end
            ST_BYTE_LEFT, ST_BYTE_RIGHT:
            begin
               resume_reg <= after_byte;
               idx_reg <= 5'h00;
               case (cur_class)
                  CLS_NOP:
                     state_reg <= after_byte;
                  CLS_FORMAT:
                  begin
                     action_reg <= action_of(cur_byte);
                     state_reg <= (count_reg == 5'h00) ? ST_ADVANCE : ST_PRINT;
                  end
                  default:
                  begin
                     count_reg <= count_reg + 5'h01;
                     if (count_reg == LAST_COL_IDX)
                     begin
                        action_reg <= ADV_NONE;
                        state_reg <= ST_PRINT;
                     end
                     else
                        state_reg <= after_byte;
                  end
               endcase
            end
            ST_PRINT:
            begin
               idx_reg <= idx_reg + 5'h01;
               if (idx_reg + 5'h01 == count_reg || idx_reg == LAST_COL_IDX)
               begin
                  count_reg <= 5'h00;
                  lines_reg <= lines_reg + 16'h0001;
                  state_reg <= (action_reg == ADV_NONE) ? resume_reg : ST_ADVANCE;
               end
            end
            ST_ADVANCE:
            begin
               settle_reg <= 8'(ADV_MIN_CYC);
               state_reg <= ST_SETTLE;
            end
            ST_SETTLE:
            begin
               if (settle_reg != 8'h00)
                  settle_reg <= settle_reg - 8'h01;
               else if (!pins_sync_reg.busy)
                  state_reg <= resume_reg;
            end
            default:
               state_reg <= ST_FILL;
         endcase
      end
   end

   // printer outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prn_strobe <= 1'b0;
         prn_char <= 8'h00;
         prn_column <= 5'h00;
         prn_advance <= 1'b0;
         prn_action <= ADV_NONE;
      end
      else
      begin
         prn_strobe <= state_reg == ST_PRINT;
         prn_char <= (state_reg == ST_PRINT) ? line_buf[idx_reg] : 8'h00;
         prn_column <= (state_reg == ST_PRINT) ? idx_reg + 5'h01 : 5'h00;
         prn_advance <= state_reg == ST_ADVANCE;
         if (state_reg == ST_ADVANCE)
            prn_action <= action_reg;
      end
   end

   // APB slave: one wait state, answer on the second access cycle
   logic apb_access;
   logic ctrl_sel;
   logic status_sel;
   logic lines_sel;
   assign apb_access = psel && penable && !pready;
   assign ctrl_sel = paddr == CTRL_OFFSET;
   assign status_sel = paddr == STATUS_OFFSET;
   assign lines_sel = paddr == LINES_OFFSET;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= apb_access;
         pslverr <= apb_access && !(ctrl_sel || status_sel || lines_sel) ||
                    apb_access && pwrite && !ctrl_sel;
         prdata <= 32'h0000_0000;
         if (apb_access && !pwrite)
         begin
            if (ctrl_sel)
               prdata <= {24'h00_0000, dev_addr_reg};
            else if (status_sel)
            begin
               prdata[STS_ALLOW_BIT] <= allow_reg;
               prdata[STS_SRQ_BIT] <= srq_reg;
               prdata[STS_NOT_READY_BIT] <= not_ready;
               prdata[STS_COUNT_LSB +: 5] <= count_reg;
               prdata[STS_STATE_LSB +: 3] <= state_reg;
            end
            else if (lines_sel)
               prdata <= {16'h0000, lines_reg};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dev_addr_reg <= DEV_ADDR_RESET;
      else if (apb_access && pwrite && ctrl_sel)
         dev_addr_reg <= pwdata[7:0];
   end

endmodule
`default_nettype wire

// *** dv/lp_ctrl_assertions.sv ***
// port checks for the line printer controller
// assumes one pclk domain and the reset device address
`timescale 1ns/1ns
`default_nettype none
module lp_ctrl_chk
   import lp_ctrl_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // host I/O bus
   input wire io_req_t io_req,
   input wire logic precedence_in,
   input wire logic io_ack,
   input wire logic io_rvalid,
   input wire logic [15:0] io_rdata,
   input wire logic service_req,
   // printer
   input wire logic prn_strobe,
   input wire logic [7:0] prn_char,
   input wire logic [4:0] prn_column
);
   logic co_hit;
   logic op_ok;
   logic ai_hit;
   logic allow_m;
   logic was_dout;
   logic [7:0] gap;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   assign co_hit = io_req.strobe && io_req.kind == KIND_CONTROL_OUT
      && io_req.device_select_field == DEV_ADDR_RESET;
   assign op_ok = io_req.wdata[7:0] == OP_INHIBIT || io_req.wdata[7:0] == OP_ALLOW;
   assign ai_hit = io_req.strobe && io_req.kind == KIND_ADDRESS_IN;

   // bit 3 tells allow from inhibit; gap saturates so reset never looks recent
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         allow_m <= 1'b0;
         was_dout <= 1'b0;
         gap <= 8'hFF;
      end
      else
      begin
         if (co_hit && op_ok)
            allow_m <= io_req.wdata[3];
         was_dout <= io_req.strobe && io_req.kind == KIND_DATA_OUT;
         if (io_ack && was_dout)
            gap <= 8'h00;
         else if (gap != 8'hFF)
            gap <= gap + 8'h01;
      end
   end

   property p_co_ack;
      co_hit && op_ok |=> io_ack;
   endproperty
   a_co_ack: assert property (p_co_ack) else $error("mode code not acked");
   property p_co_bad;
      io_req.strobe && io_req.kind == KIND_CONTROL_OUT && !(co_hit && op_ok) |=> !io_ack;
   endproperty
   a_co_bad: assert property (p_co_bad) else $error("bad control acked");
   property p_co_quiet;
      co_hit |=> !$rose(service_req);
   endproperty
   a_co_quiet: assert property (p_co_quiet) else $error("control raised request");
   property p_in_noack;
      io_req.strobe && io_req.kind[1] |=> !io_ack;
   endproperty
   a_in_noack: assert property (p_in_noack) else $error("input acked");
   // an allow-mode ack leaves a pending request alone; only data out and inhibit drop it
   property p_ack_drop;
      io_ack && (was_dout || !allow_m) |-> !service_req;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("request kept over ack");
   property p_ai_hit;
      ai_hit && service_req && precedence_in |=>
         io_rvalid && io_rdata[7:0] == DEV_ADDR_RESET && !service_req;
   endproperty
   a_ai_hit: assert property (p_ai_hit) else $error("address answer wrong");
   property p_ai_miss;
      ai_hit && !(service_req && precedence_in) |=> io_rdata == 16'h0000;
   endproperty
   a_ai_miss: assert property (p_ai_miss) else $error("address given unasked");
   property p_holdoff;
      $rose(service_req) |-> gap >= 8'hC7;
   endproperty
   a_holdoff: assert property (p_holdoff) else $error("request too soon");
   property p_inhibit;
      !allow_m |-> !service_req;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("request while inhibited");
   property p_column;
      prn_strobe |-> prn_column >= 5'h01 && prn_column <= 5'h14 && prn_char[6:0] != 7'h00;
   endproperty
   a_column: assert property (p_column) else $error("bad printed column");

   c_srq: cover property ($rose(service_req));
   c_ai: cover property (ai_hit && service_req && precedence_in);
   c_full: cover property (prn_strobe && prn_column == 5'h14);
endmodule

bind line_printer_io_controller lp_ctrl_chk chk (.pclk, .presetn, .io_req, .precedence_in,
   .io_ack, .io_rvalid, .io_rdata, .service_req, .prn_strobe, .prn_char, .prn_column);
`default_nettype wire

// *** dv/lp_printer_model.sv ***
// behavioural printer: records printed columns, busy after each advance
// assumes one-cycle strobe and advance pulses on pclk
`timescale 1ns/1ns
`default_nettype none
module lp_printer_model
   import lp_ctrl_pkg::*;
(
   // clock
   input wire logic pclk,
   // bench control: off-line with paper fault
   input wire logic fault,
   // controller side
   input wire logic prn_strobe,
   input wire logic [7:0] prn_char,
   input wire logic [4:0] prn_column,
   input wire logic prn_advance,
   output printer_pins_t prn_pins
);
   logic [7:0] line_buf [1:20];
   int n_str = 0;
   int busy_cnt = 0;
   int n_adv = 0;

   assign prn_pins = '{1'b1, 1'b0, fault, 1'b0, !fault, busy_cnt != 0};

   // paper motion keeps busy up long enough to be seen through the sync
   always @(posedge pclk)
   begin
      if (prn_strobe)
      begin
         line_buf[prn_column] <= prn_char;
         n_str <= n_str + 1;
      end
      if (prn_advance)
      begin
         busy_cnt <= 15;
         n_adv <= n_adv + 1;
      end
      else if (busy_cnt != 0)
         busy_cnt <= busy_cnt - 1;
   end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// bench for the line printer controller: APB, host I/O bus, printer model
// assumes one-cycle I/O answers and a registered APB slave
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import lp_ctrl_pkg::*;
;
   localparam logic [7:0] DA = DEV_ADDR_RESET;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, precedence_in, fault, ak, er;
   logic io_ack, io_rvalid, service_req, precedence_out, prn_strobe, prn_advance;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rw;
   logic [15:0] io_rdata, rd;
   logic [7:0] prn_char;
   logic [4:0] prn_column;
   io_req_t io_req;
   printer_pins_t prn_pins;
   paper_action_t prn_action;
   int n_mismatch = 0;
   int compares = 0;
   int n, base, k;

   always #5 pclk = ~pclk;

   line_printer_io_controller uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .io_req, .precedence_in, .io_ack, .io_rvalid,
      .io_rdata, .service_req, .precedence_out, .prn_pins, .prn_strobe, .prn_char,
      .prn_column, .prn_advance, .prn_action);
   lp_printer_model pm (.pclk, .fault, .prn_strobe, .prn_char, .prn_column,
      .prn_advance, .prn_pins);

   task print_verdict;
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task fail;
      n_mismatch++;
      print_verdict;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      rw = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
         fail;
      @(posedge pclk);
   endtask

   task io(input instr_kind_t kd, input logic [7:0] s, input logic [15:0] w);
      io_req <= '{1'b1, kd, s, w};
      @(posedge pclk);
      io_req.strobe <= 1'b0;
      @(posedge pclk);
      ak = io_ack;
      rd = io_rdata;
   endtask

   task wsrq;
      for (n = 0; n < 1000 && service_req !== 1'b1; n++)
         @(posedge pclk);
      if (service_req !== 1'b1)
         fail;
   endtask

   task send(input logic [15:0] w);
      io(KIND_DATA_OUT, DA, w);
      chk(ak, 1'b1);
   endtask

   task put(input logic [15:0] w);
      wsrq;
      send(w);
   endtask

   task s_regs;
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rw[7:0], DA);
      apb(1'b1, CTRL_OFFSET, {24'h0, DA});
      chk(er, 1'b0);
      apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF);
      chk(er, 1'b1);
      apb(1'b0, 12'hFFC, 32'h0);
      chk(er, 1'b1);
   endtask

   task s_mode;
      io(KIND_CONTROL_OUT, 8'h2B, {8'h00, OP_ALLOW});
      chk(ak, 1'b0);
      io(KIND_CONTROL_OUT, DA, 16'h000C);
      chk(ak, 1'b0);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rw[STS_ALLOW_BIT], 1'b0);
      io(KIND_CONTROL_OUT, DA, {8'h00, OP_INHIBIT});
      chk(ak, 1'b1);
      io(KIND_CONTROL_OUT, DA, {8'h00, OP_ALLOW});
      chk(ak, 1'b1);
      chk(service_req, 1'b0);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rw[STS_ALLOW_BIT], 1'b1);
   endtask

   task s_stat(input logic f);
      fault <= f;
      repeat (5) @(posedge pclk);
      io(KIND_STATUS_IN, DA, 16'h0);
      chk(rd[STAT_NOT_READY_BIT], f);
      chk(ak, 1'b0);
   endtask

   task s_data;
      io(KIND_DATA_OUT, 8'h2B, 16'h4142);
      chk(ak, 1'b0);
      send(16'h4142);
      io(KIND_DATA_OUT, DA, 16'h4343);
      chk(ak, 1'b0);
      wsrq;
      // two edges already spent on the refused word
      chk(n >= SRQ_HOLDOFF_CYC - 2, 1'b1);
      put(16'h4300);
      put(16'h0044);
      put(16'h000D);
      wsrq;
      chk(pm.line_buf[2], 8'h42);
      chk(pm.line_buf[4], 8'h44);
      chk(pm.n_str, 4);
      chk(prn_action, ADV_CARRIAGE_RET);
      chk(pm.n_adv, 1);
   endtask

   task s_line;
      base = pm.n_str;
      for (k = 0; k < 10; k++)
         put(16'h4142 + 16'(k) * 16'h0202);
      wsrq;
      chk(pm.n_str - base, 20);
      chk(pm.line_buf[20], 8'h54);
      put(16'h5A00);
      put(16'h0A00);
      wsrq;
      chk(pm.line_buf[1], 8'h5A);
      chk(prn_action, ADV_PAPER_FEED);
      put(16'h000C);
      wsrq;
      chk(prn_action, ADV_FORM_FEED);
      // full line moved no paper: only the feed and the form feed count
      chk(pm.n_adv, 3);
   endtask

   task s_clear;
      io(KIND_STATUS_IN, DA, 16'h0);
      chk(service_req, 1'b0);
      send(16'h0000);
      wsrq;
      precedence_in <= 1'b0;
      io(KIND_ADDRESS_IN, 8'h00, 16'h0);
      chk(rd, 16'h0000);
      chk(service_req, 1'b1);
      precedence_in <= 1'b1;
      io(KIND_ADDRESS_IN, 8'hFF, 16'h0);
      chk(rd[7:0], DA);
      chk(ak, 1'b0);
      chk(service_req, 1'b0);
      // chain output lags the request by one edge
      chk(precedence_out, 1'b0);
      @(posedge pclk);
      chk(precedence_out, 1'b1);
      send(16'h0000);
      wsrq;
      fault <= 1'b1;
      repeat (5) @(posedge pclk);
      io(KIND_DATA_OUT, DA, 16'h4141);
      chk(ak, 1'b0);
      fault <= 1'b0;
      repeat (5) @(posedge pclk);
      io(KIND_CONTROL_OUT, DA, {8'h00, OP_INHIBIT});
      chk(service_req, 1'b0);
      send(16'h0000);
      repeat (300) @(posedge pclk);
      chk(service_req, 1'b0);
   endtask

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      io_req = '0;
      precedence_in = 1'b1;
      fault = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs;
      s_mode;
      s_stat(1'b1);
      s_stat(1'b0);
      s_data;
      s_line;
      s_clear;
      print_verdict;
   end
endmodule
`default_nettype wire
